// *** design/lsc_pkg.sv ***
// Package: register map, field layout and interface types for the link status / slot caps bank
package lsc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] LINK_STATUS_IDX = 8'h52;
  localparam logic [ADDR_W-1:0] SLOT_CAPS_IDX = 8'h54;
  localparam logic [ADDR_W-1:0] SLOT_ENABLE_IDX = 8'h60;
  localparam logic [ADDR_W-1:0] LINK_EVENTS_IDX = 8'h64;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_IDX = 8'h68;
  localparam logic [ADDR_W-1:0] IRQ_MASK_IDX = 8'h6C;
  localparam logic [9:0] BYTE_ADDR_MUL = 10'h004;
  localparam logic [3:0] RATE_CODE_2G5 = 4'h1;
  localparam logic [2:0] LSTS_RSVD = 3'h0;
  localparam logic [5:0] LANE_RESET = 6'h00;
  localparam int CAPS_W = 17;
  localparam logic [CAPS_W-1:0] CAPS_RESET = 17'h00000;
  localparam logic [CAPS_W-1:0] CAPS_ZERO = 17'h00000;
  localparam int CAPS_UPPER_W = DATA_W - CAPS_W;
  localparam logic [CAPS_UPPER_W-1:0] CAPS_UPPER_ZERO = 15'h0000;
  localparam int LSTS_UPPER_W = 16;
  localparam logic [LSTS_UPPER_W-1:0] LSTS_UPPER_ZERO = 16'h0000;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 3'h0;
  localparam int IRQ_UPPER_W = DATA_W - IRQ_W;
  localparam logic [IRQ_UPPER_W-1:0] IRQ_UPPER_ZERO = 29'h00000000;
  localparam int IRQ_TRAIN_FAULT = 0;
  localparam int IRQ_LINK_UP = 1;
  localparam int IRQ_MSG_SENT = 2;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
  localparam int EVT_UP_BIT = 0;
  localparam int EVT_FAULT_BIT = 1;
  localparam int EVT_TRAIN_BIT = 2;

  // Link status, bits 15:0
  typedef struct packed {
    logic [2:0] reserved;
    logic shared_clock;
    logic training_active_flag;
    logic training_fault_flag;
    logic [5:0] negotiated_lane_count;
    logic [3:0] current_rate_code;
  } link_status_t;

  // Slot capabilities, bits 16:0
  typedef struct packed {
    logic [1:0] power_limit_scale;
    logic [7:0] power_limit_value;
    logic hotplug_capable;
    logic surprise_removal_allowed;
    logic power_lamp_present;
    logic attention_lamp_present;
    logic retention_latch_sensor_present;
    logic power_controller_present;
    logic button_present;
  } slot_caps_t;

  typedef struct packed {
    logic [7:0] value;
    logic [1:0] scale;
  } power_msg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic dl_up;
    logic training_active;
    logic training_failed;
    logic [5:0] lane_count;
  } link_state_t;
endpackage : lsc_pkg

// *** design/sync2.sv ***
// Two-stage synchroniser for one level
`timescale 1ns/1ps
module sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_t;
  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt.meta = din;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.sync;
endmodule : sync2

// *** design/power_msg_gen.sv ***
// Slot power limit message request generator with hold-until-accepted
`timescale 1ns/1ps
module power_msg_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cap_written,
  input wire logic dl_up,
  input wire lsc_pkg::power_msg_t limit,
  input wire logic msg_ready,
  output logic msg_valid,
  output lsc_pkg::power_msg_t msg_payload,
  output logic msg_sent
);
  typedef struct packed {
    logic dl_up_prev;
    logic pending;
    lsc_pkg::power_msg_t payload;
  } gen_state_t;
  gen_state_t st_r;
  gen_state_t st_nxt;
  logic trigger;
  logic accept;

  always_comb begin
    trigger = cap_written || (dl_up && !st_r.dl_up_prev);
    accept = st_r.pending && msg_ready;
    st_nxt = st_r;
    st_nxt.dl_up_prev = dl_up;
    // A new trigger reloads the payload so the latest limit is always sent
    if (trigger) begin
      st_nxt.pending = 1'b1;
      st_nxt.payload = limit;
    end else if (accept) begin
      st_nxt.pending = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign msg_valid = st_r.pending;
  assign msg_payload = st_r.payload;
  assign msg_sent = accept;
endmodule : power_msg_gen

// *** design/link_slot_regs.sv ***
// Link status and slot capabilities register bank for one switch port
//
// Operation
// [R01] The rate field in link status bits 3:0 always reads 0x1 for 2.5 Gbps and ignores writes.
// [R02] Link status bits 9:4 report the lane count found by link training, read-only.
// [R03] Link status bit 10 is a read-only flag set on a training failure, reset to zero.
// [R04] Link status bit 11 is high exactly while link training is running.
// [R05] Link status bit 12 says the port shares the platform reference clock of the slot.
// [R06] At reset bit 12 is loaded from the upstream clock pin on port 0, else the downstream pin.
// [R07] A value from the configuration memory load may replace the pin value of bit 12.
// [R08] Slot caps bits 0 to 4 flag button, power controller, latch sensor, two lamps.
// [R09] Slot caps bit 5 flags that a card may be pulled without notice.
// [R10] Slot caps bit 6 flags hot-plug support for the slot.
// [R11] With the slot-implemented bit clear, all slot caps read zero and ignore writes.
// [R12] Slot caps bits 14:7 hold the power limit value, scaled by the scale field.
// [R13] A power limit message goes out on each caps write and each rise of link up.
// [R14] Slot caps bits 16:15 choose scale 1.0, 0.1, 0.01 or 0.001.
// [R15] Link status bits 15:13 read zero and ignore writes.
`timescale 1ns/1ps
module link_slot_regs #(
  parameter logic [1:0] PORT_INDEX = 2'h0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [lsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lsc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic upstream_shared_clock_pin,
  input wire logic downstream_shared_clock_pin,
  input wire logic cfg_load_valid,
  input wire logic cfg_load_shared_clock,
  input wire logic slot_implemented,
  input wire logic dl_up,
  input wire logic training_active,
  input wire logic training_failed,
  input wire logic [5:0] lane_count,
  input wire logic msg_ready,
  output logic msg_valid,
  output lsc_pkg::power_msg_t msg_payload,
  output logic irq
);
  // ------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  logic us_pin_s;
  logic ds_pin_s;
  logic dl_up_s;
  logic train_act_s;
  logic train_fail_s;
  logic slot_impl_s;

  sync2 u_sync_us (.clk(clk), .rst_n(rst_n), .din(upstream_shared_clock_pin), .dout(us_pin_s));
  sync2 u_sync_ds (.clk(clk), .rst_n(rst_n), .din(downstream_shared_clock_pin), .dout(ds_pin_s));
  sync2 u_sync_up (.clk(clk), .rst_n(rst_n), .din(dl_up), .dout(dl_up_s));
  sync2 u_sync_ta (.clk(clk), .rst_n(rst_n), .din(training_active), .dout(train_act_s));
  sync2 u_sync_tf (.clk(clk), .rst_n(rst_n), .din(training_failed), .dout(train_fail_s));
  sync2 u_sync_si (.clk(clk), .rst_n(rst_n), .din(slot_implemented), .dout(slot_impl_s));

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] fill;
    logic strap_done;
    logic shared_clock;
    logic [5:0] lane_count;
    logic fault;
    logic train_prev;
    logic up_prev;
    lsc_pkg::slot_caps_t caps;
    logic [lsc_pkg::IRQ_W-1:0] irq_status;
    logic [lsc_pkg::IRQ_W-1:0] irq_mask;
    logic [lsc_pkg::DATA_W-1:0] rdata;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;

  lsc_pkg::link_status_t lsts;
  lsc_pkg::slot_caps_t caps_view;
  lsc_pkg::slot_caps_t caps_wr;
  lsc_pkg::power_msg_t limit;
  logic caps_written;
  logic msg_sent;
  logic wr_lsts;
  logic wr_caps;
  logic rd_irq;
  logic [lsc_pkg::IRQ_W-1:0] events;
  logic [lsc_pkg::ADDR_W-1:0] lsts_word;
  logic [lsc_pkg::ADDR_W-1:0] caps_word;

  // ------------------------------------------------------------
  // Register views
  // ------------------------------------------------------------
  always_comb begin
    lsts.current_rate_code = lsc_pkg::RATE_CODE_2G5; // R01
    lsts.negotiated_lane_count = st_r.lane_count; // R02
    lsts.training_fault_flag = st_r.fault; // R03
    lsts.training_active_flag = train_act_s; // R04
    lsts.shared_clock = st_r.shared_clock; // R05
    lsts.reserved = lsc_pkg::LSTS_RSVD; // R15
  end

  assign caps_view = slot_impl_s ? st_r.caps : lsc_pkg::CAPS_ZERO; // R11
  // A write must announce the new limit, not the one it replaces
  assign limit.value = caps_written ? caps_wr.power_limit_value
                                    : caps_view.power_limit_value; // R12
  assign limit.scale = caps_written ? caps_wr.power_limit_scale
                                    : caps_view.power_limit_scale; // R14

  // Status offsets are not word aligned, so each is an index at four bytes a step
  assign lsts_word = lsc_pkg::LINK_STATUS_IDX;
  assign caps_word = lsc_pkg::SLOT_CAPS_IDX;
  assign wr_lsts = reg_wr && (reg_addr == lsts_word);
  assign wr_caps = reg_wr && (reg_addr == caps_word);
  assign rd_irq = reg_rd && (reg_addr == lsc_pkg::IRQ_STATUS_IDX);
  assign caps_wr = reg_wdata[lsc_pkg::CAPS_W-1:0];
  // Of caps writes, only one to an implemented slot fires a message
  assign caps_written = wr_caps && slot_impl_s; // R13

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.train_prev = train_act_s;
    st_nxt.up_prev = dl_up_s;

    // Strap waits until the pin synchronisers have filled after reset
    st_nxt.fill = {st_r.fill[0], 1'b1};
    if (st_r.fill[1] && !st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.shared_clock = (PORT_INDEX == 2'h0) ? us_pin_s : ds_pin_s; // R06
    end
    if (cfg_load_valid) begin
      st_nxt.shared_clock = cfg_load_shared_clock; // R07
    end

    // Width is latched at the end of training
    if (st_r.train_prev && !train_act_s) begin
      st_nxt.lane_count = lane_count; // R02
    end

    // Fault clears when a new training starts; set wins over clear
    if (train_act_s && !st_r.train_prev) begin
      st_nxt.fault = 1'b0;
    end
    if (train_fail_s) begin
      st_nxt.fault = 1'b1; // R03
    end

    if (caps_written) begin // R11
      st_nxt.caps.button_present = caps_wr.button_present; // R08
      st_nxt.caps.power_controller_present = caps_wr.power_controller_present; // R08
      st_nxt.caps.retention_latch_sensor_present = caps_wr.retention_latch_sensor_present; // R08
      st_nxt.caps.attention_lamp_present = caps_wr.attention_lamp_present; // R08
      st_nxt.caps.power_lamp_present = caps_wr.power_lamp_present; // R08
      st_nxt.caps.surprise_removal_allowed = caps_wr.surprise_removal_allowed; // R09
      st_nxt.caps.hotplug_capable = caps_wr.hotplug_capable; // R10
      st_nxt.caps.power_limit_value = caps_wr.power_limit_value; // R12
      st_nxt.caps.power_limit_scale = caps_wr.power_limit_scale; // R14
    end

    // Writes to link status change nothing: every field is read-only
    events = lsc_pkg::IRQ_ZERO;
    events[lsc_pkg::IRQ_TRAIN_FAULT] = train_fail_s && !st_r.fault;
    events[lsc_pkg::IRQ_LINK_UP] = dl_up_s && !st_r.up_prev;
    events[lsc_pkg::IRQ_MSG_SENT] = msg_sent;
    if (rd_irq) begin
      st_nxt.irq_status = lsc_pkg::IRQ_ZERO;
    end
    st_nxt.irq_status = st_nxt.irq_status | events;
    if (reg_wr && (reg_addr == lsc_pkg::IRQ_MASK_IDX)) begin
      st_nxt.irq_mask = reg_wdata[lsc_pkg::IRQ_W-1:0];
    end

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = lsc_pkg::WORD_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        lsc_pkg::LINK_STATUS_IDX: st_nxt.rdata = {lsc_pkg::LSTS_UPPER_ZERO, lsts};
        lsc_pkg::SLOT_CAPS_IDX: st_nxt.rdata = {lsc_pkg::CAPS_UPPER_ZERO, caps_view};
        lsc_pkg::LINK_EVENTS_IDX: begin
          st_nxt.rdata[lsc_pkg::EVT_UP_BIT] = dl_up_s;
          st_nxt.rdata[lsc_pkg::EVT_FAULT_BIT] = st_r.fault;
          st_nxt.rdata[lsc_pkg::EVT_TRAIN_BIT] = train_act_s;
        end
        lsc_pkg::SLOT_ENABLE_IDX: st_nxt.rdata[0] = slot_impl_s;
        lsc_pkg::IRQ_STATUS_IDX: st_nxt.rdata = {lsc_pkg::IRQ_UPPER_ZERO, st_r.irq_status};
        lsc_pkg::IRQ_MASK_IDX: st_nxt.rdata = {lsc_pkg::IRQ_UPPER_ZERO, st_r.irq_mask};
        default: st_nxt.rdata = lsc_pkg::WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Power limit message
  // ------------------------------------------------------------
  power_msg_gen u_msg (
    .clk(clk),
    .rst_n(rst_n),
    .cap_written(caps_written),
    .dl_up(dl_up_s),
    .limit(limit),
    .msg_ready(msg_ready),
    .msg_valid(msg_valid),
    .msg_payload(msg_payload),
    .msg_sent(msg_sent)
  ); // R13

  assign reg_rdata = st_r.rdata;
  assign irq = |(st_r.irq_status & st_r.irq_mask);
endmodule : link_slot_regs

// *** dv/link_slot_regs_sva.sv ***
// Assertion checker for the link status and slot caps bank
`timescale 1ns/1ps
module link_slot_regs_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic slot_implemented,
  input wire logic dl_up,
  input wire logic training_active,
  input wire logic msg_ready,
  input wire logic msg_valid,
  input wire lsc_pkg::power_msg_t msg_payload
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rd_ls;
    reg_rd && reg_addr == lsc_pkg::LINK_STATUS_IDX;
  endsequence
  sequence s_rd_sc;
    reg_rd && reg_addr == lsc_pkg::SLOT_CAPS_IDX;
  endsequence
  sequence s_wr_sc;
    reg_wr && reg_addr == lsc_pkg::SLOT_CAPS_IDX;
  endsequence
  // Four cycles of a level cover the input synchroniser
  property p_rate;
    s_rd_ls |=> reg_rdata[3:0] == 4'h1;
  endproperty
  property p_rsvd;
    s_rd_ls |=> reg_rdata[31:13] == 19'h00000;
  endproperty
  property p_train_on;
    training_active[*4] ##0 s_rd_ls |=> reg_rdata[11] == 1'h1;
  endproperty
  property p_train_off;
    !training_active[*4] ##0 s_rd_ls |=> reg_rdata[11] == 1'h0;
  endproperty
  property p_caps_off;
    !slot_implemented[*4] ##0 s_rd_sc |=> reg_rdata == 32'h00000000;
  endproperty
  property p_msg_wr;
    slot_implemented[*4] ##0 s_wr_sc |=> msg_valid
      && msg_payload == {$past(reg_wdata[14:7]), $past(reg_wdata[16:15])};
  endproperty
  property p_hold;
    msg_valid && !msg_ready && !reg_wr |=> msg_valid;
  endproperty
  property p_link_up;
    $rose(dl_up) |-> ##[1:5] msg_valid;
  endproperty
  a_rate: assert property (p_rate) else $error("rate code wrong");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  a_train_on: assert property (p_train_on) else $error("training flag low");
  a_train_off: assert property (p_train_off) else $error("training flag high");
  a_caps_off: assert property (p_caps_off) else $error("caps not zero");
  a_msg_wr: assert property (p_msg_wr) else $error("no message on write");
  a_hold: assert property (p_hold) else $error("message dropped");
  a_link_up: assert property (p_link_up) else $error("no message on link up");
endmodule : link_slot_regs_sva

bind link_slot_regs link_slot_regs_sva link_slot_regs_sva_inst (.clk, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slot_implemented, .dl_up, .training_active,
  .msg_ready, .msg_valid, .msg_payload);

// *** dv/link_slot_regs_bench.sv ***
// Self-checking bench for the link status and slot caps bank
`timescale 1ns/1ps
module link_slot_regs_bench;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic ld_v = 1'h0;
  logic slot = 1'h0;
  logic dl_up = 1'h0;
  logic t_act = 1'h0;
  logic t_fail = 1'h0;
  logic msg_ready = 1'h0;
  logic [5:0] lanes = 6'h00;
  logic msg_valid;
  logic irq;
  lsc_pkg::power_msg_t msg_payload;
  int fail_count = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  link_slot_regs link_slot_regs_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .upstream_shared_clock_pin(1'h1), .downstream_shared_clock_pin(1'h0),
    .cfg_load_valid(ld_v), .cfg_load_shared_clock(1'h0), .slot_implemented(slot),
    .dl_up(dl_up), .training_active(t_act), .training_failed(t_fail), .lane_count(lanes),
    .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_payload(msg_payload), .irq(irq));
  // ----------------
  // Bus and check tasks
  // ----------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, exp);
  endtask : rdc
  task msg(input logic [9:0] exp);
    chk({21'h0, msg_valid, msg_payload}, {21'h1, exp});
    @(posedge clk);
    msg_ready <= 1'h1;
    @(posedge clk);
    msg_ready <= 1'h0;
  endtask : msg
  task sy;
    repeat (4) @(posedge clk);
    #1;
  endtask : sy
  task results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  // ----------------
  // Tests
  // ----------------
  initial begin
    #50000;
    fail_count++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    repeat (6) @(posedge clk);
    rdc(8'h52, 32'h00001001);
    wr(8'h52, 32'hFFFFFFFF);
    rdc(8'h52, 32'h00001001);
    @(posedge clk) ld_v <= 1'h1;
    @(posedge clk) ld_v <= 1'h0;
    rdc(8'h52, 32'h00000001);
    @(posedge clk) t_act <= 1'h1;
    sy();
    rdc(8'h52, 32'h00000801);
    @(posedge clk);
    lanes <= 6'h04;
    t_fail <= 1'h1;
    t_act <= 1'h0;
    sy();
    rdc(8'h52, 32'h00000441);
    chk({31'h0, irq}, 32'h0);
    wr(8'h6C, 32'h1);
    @(posedge clk) t_fail <= 1'h0;
    sy();
    chk({31'h0, irq}, 32'h1);
    rdc(8'h68, 32'h1);
    sy();
    chk({31'h0, irq}, 32'h0);
    wr(8'h54, 32'hFFFFFFFF);
    chk({31'h0, msg_valid}, 32'h0);
    rdc(8'h54, 32'h0);
    @(posedge clk) slot <= 1'h1;
    sy();
    wr(8'h54, 32'hFFFFFFFF);
    rdc(8'h54, 32'h0001FFFF);
    msg({8'hFF, 2'h3});
    wr(8'h54, 32'h00000020);
    msg({8'h00, 2'h0});
    rdc(8'h54, 32'h00000020);
    wr(8'h54, 32'h00000040);
    msg({8'h00, 2'h0});
    rdc(8'h54, 32'h00000040);
    for (int s = 0; s < 4; s++) begin
      wr(8'h54, {15'h0, s[1:0], 8'hA5, 7'h2A});
      msg({8'hA5, s[1:0]});
      rdc(8'h54, {15'h0, s[1:0], 8'hA5, 7'h2A});
    end
    @(posedge clk) dl_up <= 1'h1;
    for (int i = 0; i < 8 && msg_valid !== 1'h1; i++) @(posedge clk);
    #1;
    msg({8'hA5, 2'h3});
    wr(8'h6C, 32'h7);
    sy();
    chk({31'h0, irq}, 32'h1);
    rdc(8'h68, 32'h6);
    rdc(8'h70, 32'h0);
    // Second reset in mid-run: strap reloads, link up sends the reset limit
    @(posedge clk) resetn <= 1'h0;
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    repeat (6) @(posedge clk);
    rdc(8'h52, 32'h00001001);
    msg({8'h00, 2'h0});
    results();
  end
endmodule : link_slot_regs_bench
